// ### rtl/srcs_regs.sv
// Receiver channel status register bank with update flag and audio word truncation.
`timescale 1ns/10ps
// Operation
// - Status bits 15:8 form the category byte; zero means general category.
// - Status bits 19:16 give source number in low nibble of second register.
// - Bits 23:20 give channel-one number; 0001 left, 0010 right, 0000 left.
// - Bits 27:24 give sampling frequency code; 0001 means not indicated.
// - Bits 29:28 give clock accuracy in third register bits 5:4.
// - Bits 39:36 give original sampling frequency code; 0000 means not indicated.
// - Channel status is taken from subframe A only; subframe B ignored.
// - Update flag sets when a new block is stored, clears on host readback.
// - Recovered length truncates audio_trunc_q only; audio_full_q passes the word unchanged.
// - Status registers are read-only and reached through serial readback.
module srcs_regs
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire srcs_pkg::srcs_cs_s   cs_in,
  input  wire srcs_pkg::srcs_audio_s audio_in,
  input  wire logic                 rd_req,
  input  wire logic [6:0]           rd_addr,
  output logic      [7:0]           rd_data_q,
  output logic                      rd_valid_q,
  output logic                      status_update_flag_q,
  output logic                      chan1_to_right_q,
  output srcs_pkg::srcs_audio_s     audio_trunc_q,
  output srcs_pkg::srcs_audio_s     audio_full_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Length decode helpers.

  function automatic logic [4:0] wl_bits(input logic max_len, input logic [2:0] code);
    logic [4:0] top;
    top = max_len ? srcs_pkg::AUDIO_FULL_BITS : srcs_pkg::MAX_SHORT_BITS;
    case (code)
      3'b001:  wl_bits = top - 5'h04;
      3'b010:  wl_bits = top - 5'h02;
      3'b100:  wl_bits = top - 5'h01;
      3'b110:  wl_bits = top - 5'h03;
      // Not indicated, max and reserved codes all keep the full maximum.
      default: wl_bits = top;
    endcase
  endfunction

  function automatic logic [23:0] keep_mask(input logic [4:0] bits);
    logic [23:0] m;
    m = '1;
    for (int i = 0; i < 24; i++)
    begin
      if (5'(23 - i) >= bits)
      begin
        m[i] = 1'b0;
      end
    end
    keep_mask = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Block capture.

  logic [7:0]  bit_idx_q;
  logic        in_block_q;
  logic [31:0] shadow_q;
  logic [31:0] image_d;
  logic        commit;
  logic [7:0]  idx_now;
  logic        take;

  // Subframe B status bits are never counted nor stored.
  assign take    = cs_in.valid && cs_in.subframe_a;
  assign idx_now = cs_in.block_start ? 8'h00 : bit_idx_q + 8'h01;
  assign commit  = take && (cs_in.block_start || in_block_q)
                   && idx_now == srcs_pkg::CS_LAST_KEPT;

  // The last kept bit joins the shifted image in the commit cycle, so bit 8 sits at image bit 0.
  always_comb
  begin
    image_d = {cs_in.status_bit, shadow_q[31:1]};
    // Status bits 31:30 have no field in the third register, so they always read back as zero.
    image_d[srcs_pkg::ACCURACY_LSB + 2 +: 2] = 2'b00;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_idx_q  <= 8'h00;
      in_block_q <= 1'b0;
    end
    else if (take)
    begin
      bit_idx_q <= idx_now;
      // A block is trusted only after its start marker has been seen.
      if (cs_in.block_start)
      begin
        in_block_q <= 1'b1;
      end
      else if (idx_now == srcs_pkg::CS_BLOCK_LAST)
      begin
        in_block_q <= 1'b0;
      end
    end
  end

  // Bits 39:8 shift in LSB-first order, so bit 8 lands at image bit 0.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shadow_q <= srcs_pkg::RESET_IMAGE;
    end
    else if (take && idx_now >= srcs_pkg::CS_FIRST_KEPT
             && idx_now <= srcs_pkg::CS_LAST_KEPT)
    begin
      shadow_q <= {cs_in.status_bit, shadow_q[31:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register store and readback.

  logic       rd_hit;
  logic [1:0] rd_idx;

  // Offsets 2Dh..30h are consecutive, so the index is the offset minus the first.
  assign rd_hit = rd_addr >= srcs_pkg::ADDR_CATEGORY
                  && rd_addr <= srcs_pkg::ADDR_WORDLEN_ORIG;
  assign rd_idx = 2'(rd_addr - srcs_pkg::ADDR_CATEGORY);

  // The image is stored on the last kept bit: byte order follows the map.
  srcs_status_mem u_mem
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (commit),
    .wr_image  (image_d),
    .rd_en     (rd_req),
    .rd_hit    (rd_hit),
    .rd_idx    (rd_idx),
    .rd_data_q (rd_data_q)
  );

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_req;
    end
  end

  // A new block arriving in the same cycle as a readback keeps the flag set.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      status_update_flag_q <= 1'b0;
    end
    else if (commit)
    begin
      status_update_flag_q <= 1'b1;
    end
    else if (rd_req && rd_hit)
    begin
      status_update_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing and truncation driven by the stored fields.

  logic [3:0] wl_field_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wl_field_q       <= 4'h0;
      chan1_to_right_q <= 1'b0;
    end
    else if (commit)
    begin
      wl_field_q <= image_d[srcs_pkg::MAXLEN_BIT +: 4];
      // Only an explicit right code moves channel one; none or left stays left.
      chan1_to_right_q <= image_d[srcs_pkg::CHAN1_LSB +: 4]
                          == srcs_pkg::CHAN1_RIGHT;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      audio_trunc_q <= '0;
      audio_full_q  <= '0;
    end
    else
    begin
      audio_full_q        <= audio_in;
      audio_trunc_q.valid <= audio_in.valid;
      audio_trunc_q.word  <= audio_in.word
                             & keep_mask(wl_bits(wl_field_q[0], wl_field_q[3:1]));
    end
  end

endmodule // srcs_regs

// ### rtl/srcs_status_mem.sv
// Four-byte store of the recovered channel status with a registered read port.
`timescale 1ns/10ps
module srcs_status_mem
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_image,
  input  wire logic        rd_en,
  input  wire logic        rd_hit,
  input  wire logic [1:0]  rd_idx,
  output logic      [7:0]  rd_data_q
);

  logic [7:0] mem_q [srcs_pkg::NUM_REGS];

  // The whole block is written at once so a read never sees a mix of two blocks.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < srcs_pkg::NUM_REGS; i++)
      begin
        mem_q[i] <= srcs_pkg::READ_ZERO;
      end
    end
    else if (wr_en)
    begin
      for (int i = 0; i < srcs_pkg::NUM_REGS; i++)
      begin
        mem_q[i] <= wr_image[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= srcs_pkg::READ_ZERO;
    end
    else if (rd_en)
    begin
      rd_data_q <= rd_hit ? mem_q[rd_idx] : srcs_pkg::READ_ZERO;
    end
  end

endmodule // srcs_status_mem

// ### shared/srcs_pkg.sv
// Package with register map, field layout and carrier types for the channel status bank.
package srcs_pkg;

  localparam logic [6:0] ADDR_CATEGORY       = 7'h2d;
  localparam logic [6:0] ADDR_SOURCE_CHANNEL = 7'h2e;
  localparam logic [6:0] ADDR_SAMPLE_RATE_CODE_ACCURACY  = 7'h2f;
  localparam logic [6:0] ADDR_WORDLEN_ORIG   = 7'h30;
  localparam int         NUM_REGS            = 4;

  // Channel status bit positions within the 192-frame block.
  localparam logic [7:0] CS_FIRST_KEPT = 8'h08;
  localparam logic [7:0] CS_LAST_KEPT  = 8'h27;
  localparam logic [7:0] CS_BLOCK_LAST = 8'hbf;

  // Field positions inside the packed 32-bit image of status bits 39:8.
  localparam int CATEGORY_LSB    = 0;
  localparam int SOURCE_LSB      = 8;
  localparam int CHAN1_LSB       = 12;
  localparam int RATE_LSB        = 16;
  localparam int ACCURACY_LSB    = 20;
  localparam int MAXLEN_BIT      = 24;
  localparam int LENCODE_LSB     = 25;
  localparam int ORIG_RATE_LSB   = 28;

  localparam logic [31:0] RESET_IMAGE = 32'h0000_0000;
  localparam logic [7:0]  READ_ZERO   = 8'h00;

  localparam logic [3:0] CHAN1_NONE  = 4'h0;
  localparam logic [3:0] CHAN1_LEFT  = 4'h1;
  localparam logic [3:0] CHAN1_RIGHT = 4'h2;

  localparam logic [4:0] AUDIO_FULL_BITS = 5'h18;
  localparam logic [4:0] MAX_SHORT_BITS  = 5'h14;

  typedef struct packed {
    logic valid;
    logic subframe_a;
    logic block_start;
    logic status_bit;
  } srcs_cs_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } srcs_audio_s;

endpackage : srcs_pkg

// ### verification/srcs_decoder_model.sv
// Behavioural receiver decoder that plays channel status blocks.
`timescale 1ns/10ps
module srcs_decoder_model
(
  input  wire logic          ref_clk,
  output srcs_pkg::srcs_cs_s cs_out
);
  initial cs_out = '0;
  // Between bits the data line flips, so a sampler that ignores valid sees garbage.
  task automatic send_block(input logic [39:0] b, input logic noise);
    for (int i = 0; i < 192; i++)
    begin
      @(posedge ref_clk);
      cs_out <= {2'b11, i == 0, i < 40 && b[i % 40]};
      if (noise)
      begin
        @(posedge ref_clk);
        cs_out <= {3'b100, i >= 40 || !b[i % 40]};
      end
      @(posedge ref_clk);
      cs_out <= {3'b000, !cs_out.status_bit};
    end
  endtask
endmodule // srcs_decoder_model

// ### verification/srcs_regs_bench.sv
// Self-checking bench for the channel status register bank.
`timescale 1ns/10ps
module srcs_regs_bench;
  logic                  ref_clk;
  logic                  rst;
  logic                  rd_req;
  logic [6:0]            rd_addr;
  logic [7:0]            rd_data_q;
  logic                  rd_valid_q;
  logic                  status_update_flag_q;
  logic                  chan1_to_right_q;
  srcs_pkg::srcs_cs_s    cs_in;
  srcs_pkg::srcs_audio_s audio_in;
  srcs_pkg::srcs_audio_s audio_trunc_q;
  srcs_pkg::srcs_audio_s audio_full_q;
  int                    failures;
  int                    checks_done;
  int                    cycles;
  srcs_regs u_srcs_regs (.ref_clk, .rst, .cs_in, .audio_in, .rd_req, .rd_addr, .rd_data_q,
    .rd_valid_q, .status_update_flag_q, .chan1_to_right_q, .audio_trunc_q, .audio_full_q);
  srcs_decoder_model u_srcs_decoder_model (.ref_clk, .cs_out(cs_in));
  ////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && checks_done > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1;
    chk(rd_valid_q, 1'b1);
    chk(rd_data_q, e);
  endtask
  task automatic audio(input logic [23:0] w, input logic [23:0] e);
    @(posedge ref_clk);
    audio_in <= {1'b1, w};
    @(posedge ref_clk);
    audio_in <= '0;
    #1;
    chk(audio_trunc_q, {1'b1, e});
    chk(audio_full_q, {1'b1, w});
  endtask
  task automatic play(input logic [39:0] b, input logic noise);
    u_srcs_decoder_model.send_block(b, noise);
    chk(status_update_flag_q, 1'b1);
    rd(7'h2d, b[15:8]);
    rd(7'h2e, b[23:16]);
    rd(7'h2f, {2'b00, b[29:24]});
    rd(7'h30, b[39:32]);
    chk(status_update_flag_q, 1'b0);
  endtask
  task automatic reset_values();
    rd(7'h2d, 8'h00);
    rd(7'h2c, 8'h00);
    chk(status_update_flag_q, 1'b0);
  endtask
  task automatic block_one();
    play(40'h34_e117_a55a, 1'b0);
    chk(chan1_to_right_q, 1'b0);
    audio(24'hff_ffff, 24'hff_ffc0);
  endtask
  task automatic block_two();
    play(40'h0b_3f2c_00ff, 1'b1);
    chk(chan1_to_right_q, 1'b1);
    audio(24'hab_cdef, 24'hab_cdef);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Two blocks take under 2000 cycles, so this ceiling only trips on a hang.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    rst = 1'b1;
    rd_req = 1'b0;
    rd_addr = 7'h00;
    audio_in = '0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    reset_values();
    block_one();
    block_two();
    stop_test();
  end
endmodule // srcs_regs_bench
bind srcs_regs srcs_regs_properties u_srcs_regs_properties (.ref_clk, .rst, .cs_in, .audio_in,
  .rd_req, .rd_addr, .rd_data_q, .rd_valid_q, .status_update_flag_q, .audio_trunc_q, .audio_full_q);

// ### verification/srcs_regs_properties.sv
// Port checker for the channel status register bank.
`timescale 1ns/10ps
module srcs_regs_properties
(
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire srcs_pkg::srcs_cs_s    cs_in,
  input wire srcs_pkg::srcs_audio_s audio_in,
  input wire logic                  rd_req,
  input wire logic [6:0]            rd_addr,
  input wire logic [7:0]            rd_data_q,
  input wire logic                  rd_valid_q,
  input wire logic                  status_update_flag_q,
  input wire srcs_pkg::srcs_audio_s audio_trunc_q,
  input wire srcs_pkg::srcs_audio_s audio_full_q
);
  logic mapped;
  assign mapped = rd_addr >= 7'h2d && rd_addr <= 7'h30;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  read_answer_a: assert property (rd_req |=> rd_valid_q)
    else $error("read not answered");
  answer_once_a: assert property (!rd_req |=> !rd_valid_q)
    else $error("answer without request");
  unmapped_zero_a: assert property (rd_req && !mapped |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");
  data_hold_a: assert property (!rd_req |=> $stable(rd_data_q))
    else $error("read data moved");
  // A commit in the same cycle as a read wins, so cycles near a status bit are left out.
  flag_clear_a: assert property (status_update_flag_q && rd_req && mapped && !cs_in.valid
    && !$past(cs_in.valid) |=> !status_update_flag_q) else $error("flag not cleared");
  flag_rise_a: assert property ($rose(status_update_flag_q) |-> $past(cs_in.valid)
    || $past(cs_in.valid, 2)) else $error("flag rose without status bit");
  full_path_a: assert property (1'b1 |=> audio_full_q == $past(audio_in))
    else $error("full path altered");
  trunc_top_a: assert property (1'b1 |=> audio_trunc_q.word[23:8] == $past(audio_in.word[23:8]))
    else $error("top bits lost");
  trunc_mask_a: assert property (1'b1 |=> (audio_trunc_q.word & ~$past(audio_in.word)) == 0)
    else $error("truncation set bits");
  cover property (rd_req && mapped);
  cover property ($rose(status_update_flag_q));
  cover property ($rose(audio_trunc_q.valid));
endmodule // srcs_regs_properties
